// ===== skx_defines.svh
// offsets, field positions, reset values and bit counts for the key stream mapper
// assumes: included by bare name; widths below match the mapper's 10-bit position counters, the three subfield ones its 7-bit sub_q
`ifndef SKX_DEFINES_SVH
`define SKX_DEFINES_SVH

// ----------------------------------------------------------------------------
// tail field
// ----------------------------------------------------------------------------
`define SKX_TAIL_BITS 10'h040
`define SKX_TAIL_KEY_FIRST 10'h008
`define SKX_TAIL_KEY_LAST 10'h02F
`define SKX_TAIL_KEY_BITS 10'h028

// ----------------------------------------------------------------------------
// payload field
// ----------------------------------------------------------------------------
`define SKX_HALF_PAY_BASE 10'h050
`define SKX_DBL_PAY_BITS 10'h320
`define SKX_SINGLE_DATA_BITS 10'h300
`define SKX_XFIELD_BITS 10'h004
`define SKX_SUB_BITS 7'h50
`define SKX_SUB_DATA_BITS 7'h40

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SKX_POS_RST 10'h000
`define SKX_SUB_RST 7'h00

`endif

// ===== skx_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes: one clock, synchronous active-high reset, any depth of one or more (pointers wrap at DEPTH-1)
`timescale 1ns/100ps
`default_nettype none

module skx_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // ready and valid come straight from the fill level
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage: no reset, contents are only read while counted valid
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ===== skx_keygen_model.sv
// key stream generator model standing at the mapper's far side
// assumes: one request at a time; the bench sets seg_len_i before a request is made
`timescale 1ns/100ps
`default_nettype none

module skx_keygen_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pacing and length from the bench
    input wire logic slow_i,
    input wire logic [9:0] seg_len_i,
    // segment request
    input wire logic req_valid_i,
    input wire skx_pkg::skx_key_req_t req_i,
    output logic req_ready_o,
    // key bits
    output logic key_valid_o,
    output logic key_bit_o,
    input wire logic key_ready_i
);
    int k;
    logic [23:0] fn;
    logic seg;

    // bit k of the segment chosen by frame number and segment index
    function automatic logic kbit(input logic [23:0] f, input logic s, input logic [9:0] i);
        logic [31:0] h;
        h = {8'h00, f} * 32'h0000_0025 + {22'h0, i} * 32'h0000_009d + {31'h0, s} * 32'h0000_0b0b;
        return h[5] ^ h[2];
    endfunction

    // ----
    // request then stream, all changes just after a rising edge
    // ----
    initial
    begin
        req_ready_o = 1'b0;
        key_valid_o = 1'b0;
        key_bit_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            #1;
            req_ready_o = !rst_i && (!slow_i || $urandom_range(1) == 1);
            @(negedge clk_i);
            if (req_ready_o && req_valid_i)
            begin
                fn = req_i.frame_num;
                seg = req_i.seg;
                @(posedge clk_i);
                #1;
                req_ready_o = 1'b0;
                // exactly one segment, so a frame's pair totals twice this
                for (k = 0; k < seg_len_i; k++)
                begin
                    while (slow_i && $urandom_range(2) == 0)
                    begin
                        key_valid_o = 1'b0;
                        key_bit_o = !key_bit_o;
                        @(posedge clk_i);
                        #1;
                    end
                    key_valid_o = 1'b1;
                    key_bit_o = kbit(fn, seg, 10'(k));
                    do @(negedge clk_i); while (!key_ready_i);
                    @(posedge clk_i);
                    #1;
                end
                // released line shows no stale bit
                key_valid_o = 1'b0;
                key_bit_o = !key_bit_o;
            end
        end
    end
endmodule
`default_nettype wire

// ===== skx_mapper.sv
// key stream mapper: XORs key stream segment bits onto tail and payload bits
// assumes: descriptor, key bits and field bits all on REF_CLK_I; generator honours requests
//
// What this block does
// - each enciphered field consumes one segment of 120 + j bits (half slot)
// - control-tail: segment bits 0..39 XOR onto tail bits 8..47 in order
// - other tail types: segment bits 0..39 are consumed and discarded
// - half unprotected: segment bits 40..119+j XOR onto payload bits 0..79+j
// - half protected: bits 40..103 onto data 0..63, bits 104..119 unused
// - half protected with j above zero: bits 120.. onto payload bits 80..
// - redundancy checks and trailing check field always pass in clear
// - a half-slot frame's two segments total 240 + 2j bits
// - half unprotected payload: all 80 + j bits are channel data
// - half protected: 64 data bits then a 16-bit check
// - double unprotected payload: all 800 bits are channel data
// - double multisubfield: each subfield is 64 data bits plus 16-bit check
// - double singlesubfield: 768 data, 32-bit check, 4-bit trailing field
// - new bearer adopts current mode; same key and initial value if ciphering
// - both handover connections use the same frame-indexed segment pair
// - second connection starts clear, encryption enabled later by portable side
// - external handover: new connection starts in clear mode
// - fixed side sends with first segment, portable side with the second
// - both ends keep frame numbering in step for segment selection
`timescale 1ns/100ps
`default_nettype none
`include "skx_defines.svh"

module skx_mapper #(
    parameter int KEY_FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // role of this end
    input wire logic FIXED_SIDE_I,
    // per-field descriptor
    input wire logic FLD_VALID_I,
    input wire skx_pkg::skx_field_t FLD_I,
    output logic FLD_READY_O,
    // segment request to the key stream generator
    output logic KEY_REQ_VALID_O,
    output skx_pkg::skx_key_req_t KEY_REQ_O,
    input wire logic KEY_REQ_READY_I,
    // key stream bits from the generator
    input wire logic KEY_VALID_I,
    input wire logic KEY_BIT_I,
    output logic KEY_READY_O,
    // field bits in, tail first then payload
    input wire logic DIN_VALID_I,
    input wire logic DIN_BIT_I,
    output logic DIN_READY_O,
    // field bits out
    output logic DOUT_VALID_O,
    output logic DOUT_BIT_O,
    input wire logic DOUT_READY_I,
    // end of field
    output logic FIELD_DONE_O
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    skx_pkg::skx_state_t state_q;
    skx_pkg::skx_field_t fld_q;
    skx_pkg::skx_key_req_t req_q;
    logic [9:0] pos_q;
    logic [6:0] sub_q;
    logic [9:0] kcnt_q;
    logic dout_valid_q;
    logic dout_bit_q;
    logic done_q;

    logic key_v;
    logic key_b;
    logic key_pop;
    logic in_tail;
    logic in_pay;
    logic key_pos;
    logic apply;
    logic need_key;
    logic out_free;
    logic can_go;
    logic step;
    logic take;
    logic is_half;
    logic [9:0] klen;
    logic [9:0] plen;

    // ------------------------------------------------------------------------
    // key stream buffer
    // ------------------------------------------------------------------------
    // lets the generator run ahead a few bits while the output is stalled
    skx_fifo #(
        .WIDTH(1),
        .DEPTH(KEY_FIFO_DEPTH)
    ) u_key_fifo (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .in_valid_i(KEY_VALID_I),
        .in_data_i(KEY_BIT_I),
        .in_ready_o(KEY_READY_O),
        .out_valid_o(key_v),
        .out_data_o(key_b),
        .out_ready_i(key_pop)
    );

    // ------------------------------------------------------------------------
    // bit mapping
    // ------------------------------------------------------------------------
    // payload lengths follow slot kind and extension count
    assign is_half = (fld_q.slot == skx_pkg::SKX_HALF);
    assign klen = is_half ? (`SKX_HALF_PAY_BASE + {2'h0, fld_q.ext_j}) : `SKX_DBL_PAY_BITS;
    assign plen = klen + `SKX_XFIELD_BITS;
    assign in_tail = (state_q == skx_pkg::SKX_TAIL);
    assign in_pay = (state_q == skx_pkg::SKX_PAY);

    // which positions consume a key bit, and which of those are XORed
    always_comb
    begin
        key_pos = 1'h0;
        apply = 1'h0;
        if (in_tail)
        begin
            key_pos = (pos_q >= `SKX_TAIL_KEY_FIRST) && (pos_q <= `SKX_TAIL_KEY_LAST);
            apply = fld_q.tail_ct;
        end
        else if (in_pay)
        begin
            key_pos = (pos_q < klen);
            case (fld_q.fmt)
                skx_pkg::SKX_UNPROT: apply = 1'h1;
                skx_pkg::SKX_MULTISUB:
                begin
                    // check bits of each subfield stay clear
                    if (is_half && pos_q >= `SKX_HALF_PAY_BASE)
                    begin
                        apply = 1'h1;
                    end
                    else
                    begin
                        apply = (sub_q < `SKX_SUB_DATA_BITS);
                    end
                end
                skx_pkg::SKX_SINGLESUB: apply = (pos_q < `SKX_SINGLE_DATA_BITS);
                default: apply = 1'h0;
            endcase
        end
    end

    // one bit moves when input, key (if needed) and output slot are all there
    assign need_key = fld_q.cipher_en && key_pos;
    assign out_free = !dout_valid_q || DOUT_READY_I;
    assign can_go = (in_tail || in_pay) && out_free && (!need_key || key_v);
    assign DIN_READY_O = can_go;
    assign step = can_go && DIN_VALID_I;
    assign key_pop = step && need_key;
    assign take = (state_q == skx_pkg::SKX_IDLE) && FLD_VALID_I;
    assign FLD_READY_O = (state_q == skx_pkg::SKX_IDLE);

    // ------------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------------
    // descriptor is latched before any key bit of the field is used
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            state_q <= skx_pkg::SKX_IDLE;
            fld_q <= '0;
            req_q <= '0;
        end
        else
        begin
            case (state_q)
                skx_pkg::SKX_IDLE:
                begin
                    if (FLD_VALID_I)
                    begin
                        fld_q <= FLD_I;
                        req_q.frame_num <= FLD_I.frame_num;
                        req_q.seg <= FIXED_SIDE_I ? !FLD_I.is_tx : FLD_I.is_tx;
                        // clear-mode fields never ask for key stream
                        state_q <= FLD_I.cipher_en ? skx_pkg::SKX_REQ : skx_pkg::SKX_TAIL;
                    end
                end
                skx_pkg::SKX_REQ:
                begin
                    if (KEY_REQ_READY_I)
                    begin
                        state_q <= skx_pkg::SKX_TAIL;
                    end
                end
                skx_pkg::SKX_TAIL:
                begin
                    if (step && pos_q == `SKX_TAIL_BITS - 10'h001)
                    begin
                        state_q <= skx_pkg::SKX_PAY;
                    end
                end
                skx_pkg::SKX_PAY:
                begin
                    if (step && pos_q == plen - 10'h001)
                    begin
                        state_q <= skx_pkg::SKX_IDLE;
                    end
                end
                default: state_q <= skx_pkg::SKX_IDLE;
            endcase
        end
    end

    assign KEY_REQ_VALID_O = (state_q == skx_pkg::SKX_REQ);
    assign KEY_REQ_O = req_q;

    // bit position within tail or payload, and within the current subfield
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || take)
        begin
            pos_q <= `SKX_POS_RST;
            sub_q <= `SKX_SUB_RST;
        end
        else if (step)
        begin
            if (in_tail && pos_q == `SKX_TAIL_BITS - 10'h001)
            begin
                pos_q <= `SKX_POS_RST;
                sub_q <= `SKX_SUB_RST;
            end
            else
            begin
                pos_q <= pos_q + 10'h001;
                sub_q <= (in_pay && sub_q == `SKX_SUB_BITS - 7'h01) ? `SKX_SUB_RST : sub_q + 7'h01;
            end
        end
    end

    // key bits used in this field; only the checks below read it
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I || take)
        begin
            kcnt_q <= `SKX_POS_RST;
        end
        else if (key_pop)
        begin
            kcnt_q <= kcnt_q + 10'h001;
        end
    end

    // ------------------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------------------
    // registered so the XOR never sits on the consumer's path
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            dout_valid_q <= 1'h0;
            dout_bit_q <= 1'h0;
        end
        else if (step)
        begin
            dout_valid_q <= 1'h1;
            dout_bit_q <= DIN_BIT_I ^ (need_key & apply & key_b);
        end
        else if (DOUT_READY_I)
        begin
            dout_valid_q <= 1'h0;
        end
    end

    // end-of-field pulse
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            done_q <= 1'h0;
        end
        else
        begin
            done_q <= in_pay && step && (pos_q == plen - 10'h001);
        end
    end

    assign DOUT_VALID_O = dout_valid_q;
    assign DOUT_BIT_O = dout_bit_q;
    assign FIELD_DONE_O = done_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    tail_head_clear_a: assert property (
        (step && in_tail && pos_q < 10'h008) |-> !key_pop ##1 dout_bit_q == $past(DIN_BIT_I))
        else $error("tail head bit took key stream");
    tail_drop_a: assert property (
        (step && in_tail && !fld_q.tail_ct) |=> dout_bit_q == $past(DIN_BIT_I))
        else $error("non control tail was altered");
    unprot_xor_a: assert property (
        (step && in_pay && fld_q.cipher_en && fld_q.fmt == skx_pkg::SKX_UNPROT && pos_q < klen)
        |=> dout_bit_q == $past(DIN_BIT_I ^ key_b))
        else $error("unprotected payload bit not enciphered");
    half_data_a: assert property (
        (step && in_pay && is_half && fld_q.cipher_en && fld_q.fmt == skx_pkg::SKX_MULTISUB
        && pos_q < 10'h040) |-> key_pop ##1 dout_bit_q == $past(DIN_BIT_I ^ key_b))
        else $error("half protected data bit not enciphered");
    half_ext_a: assert property (
        (step && in_pay && is_half && fld_q.cipher_en && fld_q.fmt == skx_pkg::SKX_MULTISUB
        && pos_q >= 10'h050 && pos_q < klen) |=> dout_bit_q == $past(DIN_BIT_I ^ key_b))
        else $error("extension bit not enciphered");
    check_clear_a: assert property (
        (step && in_pay && fld_q.fmt == skx_pkg::SKX_MULTISUB && sub_q >= 7'h40
        && !(is_half && pos_q >= 10'h050)) |=> dout_bit_q == $past(DIN_BIT_I))
        else $error("subfield check bit was enciphered");
    single_tail_a: assert property (
        (step && in_pay && fld_q.fmt == skx_pkg::SKX_SINGLESUB && pos_q >= 10'h300)
        |=> dout_bit_q == $past(DIN_BIT_I))
        else $error("singlesubfield check or trailer enciphered");
    seg_len_a: assert property (
        (in_pay && step && pos_q == plen - 10'h001 && fld_q.cipher_en)
        |=> kcnt_q == `SKX_TAIL_KEY_BITS + $past(klen))
        else $error("segment length consumed is wrong");
    seg_pick_a: assert property (
        take |=> KEY_REQ_VALID_O == $past(FLD_I.cipher_en)
        && KEY_REQ_O.seg == ($past(FIXED_SIDE_I) ? !$past(FLD_I.is_tx) : $past(FLD_I.is_tx)))
        else $error("wrong segment requested");
    clear_nokey_a: assert property (
        (in_tail || in_pay) && !fld_q.cipher_en |-> !key_pop)
        else $error("clear field consumed key stream");

    half_cipher_c: cover property (FIELD_DONE_O && is_half && fld_q.cipher_en);
    dbl_multi_c: cover property (FIELD_DONE_O && fld_q.fmt == skx_pkg::SKX_MULTISUB && !is_half);
    stall_c: cover property (dout_valid_q && !DOUT_READY_I ##1 !KEY_READY_O);

endmodule

`default_nettype wire

// ===== skx_pkg.sv
// types shared by the key stream mapper and its surroundings
// assumes: nothing; every user writes skx_pkg::name
`default_nettype none
package skx_pkg;

    // slot kind of the field being processed
    typedef enum logic {SKX_HALF, SKX_DOUBLE} skx_slot_t;

    // payload layout
    typedef enum logic [1:0] {SKX_UNPROT, SKX_MULTISUB, SKX_SINGLESUB} skx_fmt_t;

    // mapper sequencing
    typedef enum logic [1:0] {SKX_IDLE, SKX_REQ, SKX_TAIL, SKX_PAY} skx_state_t;

    // per-field descriptor, taken before the first bit of the field
    typedef struct packed {
        skx_slot_t slot;
        logic tail_ct;
        skx_fmt_t fmt;
        logic [7:0] ext_j;
        logic cipher_en;
        logic is_tx;
        logic [23:0] frame_num;
    } skx_field_t;

    // request for one segment of the frame's pair
    typedef struct packed {
        logic [23:0] frame_num;
        logic seg;
    } skx_key_req_t;

endpackage

`default_nettype wire

// ===== tb_skx_mapper.sv
// self-checking bench for the key stream mapper with a generator model
// assumes: mapper and generator model on one 100 MHz clock, reset held 6 cycles
`timescale 1ns/100ps
`default_nettype none

module tb_skx_mapper;
    logic clk, rst, fixed, fld_vld, fld_rdy, kreq_vld, kreq_rdy, key_vld, key_bit, key_rdy;
    logic din_vld, din_bit, din_rdy, dout_vld, dout_bit, dout_rdy, done, slow;
    skx_pkg::skx_field_t fld;
    skx_pkg::skx_key_req_t kreq;
    skx_pkg::skx_key_req_t req_exp;
    logic [9:0] seg_len;
    logic exp_q[$];
    int errors, samples_checked, dones, nfld, cycles;

    skx_mapper dut (.REF_CLK_I(clk), .RST_I(rst), .FIXED_SIDE_I(fixed),
        .FLD_VALID_I(fld_vld), .FLD_I(fld), .FLD_READY_O(fld_rdy),
        .KEY_REQ_VALID_O(kreq_vld), .KEY_REQ_O(kreq), .KEY_REQ_READY_I(kreq_rdy),
        .KEY_VALID_I(key_vld), .KEY_BIT_I(key_bit), .KEY_READY_O(key_rdy),
        .DIN_VALID_I(din_vld), .DIN_BIT_I(din_bit), .DIN_READY_O(din_rdy),
        .DOUT_VALID_O(dout_vld), .DOUT_BIT_O(dout_bit), .DOUT_READY_I(dout_rdy),
        .FIELD_DONE_O(done));

    skx_keygen_model km (.clk_i(clk), .rst_i(rst), .slow_i(slow), .seg_len_i(seg_len),
        .req_valid_i(kreq_vld), .req_i(kreq), .req_ready_o(kreq_rdy),
        .key_valid_o(key_vld), .key_bit_o(key_bit), .key_ready_i(key_rdy));

    // ----
    // clock, output stall and hang limit
    // ----
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) dout_rdy <= #1 ($urandom_range(3) != 0);

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            end_sim();
        end
    end

    // ----
    // compares and closing
    // ----
    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: output bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // settled values at the falling edge equal those seen at the next rising edge
    always @(negedge clk)
    begin
        if (!rst && dout_vld && dout_rdy)
            chk_bit(dout_bit, exp_q.size() != 0 ? exp_q.pop_front() : 1'bx);
        if (!rst && kreq_vld && kreq_rdy)
            chk_vec({7'h00, kreq}, {7'h00, req_exp});
        if (done)
            dones++;
    end

    // ----
    // one field: descriptor, then tail, payload and trailing bits
    // ----
    task automatic run_field(input skx_pkg::skx_slot_t sl, input logic ct,
        input skx_pkg::skx_fmt_t fm, input logic [7:0] j, input logic ce, input logic tx,
        input logic fx, input logic [23:0] fr);
        skx_pkg::skx_field_t f;
        int plen;
        int n;
        int b;
        logic ap;
        logic d;
        f = {sl, ct, fm, j, ce, tx, fr};
        plen = (sl == skx_pkg::SKX_HALF) ? 80 + j : 800;
        seg_len = 10'(40 + plen);
        fixed = fx;
        req_exp = {fr, fx ? !tx : tx};
        fld = f;
        fld_vld = 1'b1;
        do @(negedge clk); while (!fld_rdy);
        @(posedge clk);
        #1;
        fld_vld = 1'b0;
        fld = ~f;
        nfld++;
        for (n = 0; n < 64 + plen + 4; n++)
        begin
            b = n - 64;
            if (n < 64)
                ap = ct && n >= 8 && n < 48;
            else if (b >= plen)
                ap = 1'b0;
            else if (fm == skx_pkg::SKX_UNPROT)
                ap = 1'b1;
            else if (fm == skx_pkg::SKX_SINGLESUB)
                ap = b < 768;
            else if (sl == skx_pkg::SKX_HALF)
                ap = b < 64 || b >= 80;
            else
                ap = (b % 80) < 64;
            d = 1'($urandom_range(1));
            if ($urandom_range(3) == 0)
            begin
                din_vld = 1'b0;
                din_bit = ~d;
                @(posedge clk);
                #1;
            end
            din_bit = d;
            din_vld = 1'b1;
            do @(negedge clk); while (!din_rdy);
            exp_q.push_back(d ^ (ap && ce
                && km.kbit(fr, req_exp.seg, 10'(n < 64 ? n - 8 : b + 40))));
            @(posedge clk);
            #1;
        end
        din_vld = 1'b0;
        chk_vec({30'h0, done, fld_rdy}, 32'h0000_0003);
    endtask

    // ----
    // main sequence
    // ----
    initial
    begin
        void'($urandom(32'hbc56));
        {rst, fixed, fld_vld, din_vld, din_bit, slow} = 6'h20;
        fld = '0;
        seg_len = 10'h078;
        repeat (6) @(posedge clk);
        #1;
        chk_vec({fld_rdy, kreq_vld, kreq, key_rdy, din_rdy, dout_vld, dout_bit, done},
            32'h8000_0010);
        rst = 1'b0;
        $display("test reset done");
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_UNPROT, 0, 1, 1, 1, 24'($urandom));
        slow = 1'b1;
        run_field(skx_pkg::SKX_HALF, 0, skx_pkg::SKX_UNPROT, 5, 1, 0, 0, 24'($urandom));
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_UNPROT, 255, 1, 1, 0, 24'($urandom));
        slow = 1'b0;
        $display("test half unprotected done");
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_MULTISUB, 0, 1, 0, 1, 24'($urandom));
        run_field(skx_pkg::SKX_HALF, 0, skx_pkg::SKX_MULTISUB, 7, 1, 1, 1, 24'($urandom));
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_MULTISUB, 255, 1, 0, 0, 24'($urandom));
        $display("test half protected done");
        run_field(skx_pkg::SKX_DOUBLE, 1, skx_pkg::SKX_UNPROT, 0, 1, 1, 1, 24'($urandom));
        run_field(skx_pkg::SKX_DOUBLE, 0, skx_pkg::SKX_MULTISUB, 0, 1, 0, 1, 24'($urandom));
        slow = 1'b1;
        run_field(skx_pkg::SKX_DOUBLE, 1, skx_pkg::SKX_SINGLESUB, 0, 1, 1, 0, 24'($urandom));
        slow = 1'b0;
        $display("test double slot done");
        // handover: two connections in one frame share the pair, the new one starts clear
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_UNPROT, 3, 0, 1, 1,
            24'h00_0a5c);
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_UNPROT, 3, 1, 1, 1,
            24'h00_0a5c);
        run_field(skx_pkg::SKX_HALF, 1, skx_pkg::SKX_UNPROT, 3, 1, 1, 1,
            24'h00_0a5c);
        run_field(skx_pkg::SKX_DOUBLE, 1, skx_pkg::SKX_MULTISUB, 0, 0, 0, 0,
            24'($urandom));
        $display("test handover done");
        repeat (200)
        begin
            if (exp_q.size() != 0)
                @(posedge clk);
        end
        #1;
        chk_vec(32'(exp_q.size()), 32'h0000_0000);
        chk_vec(32'(dones), 32'(nfld));
        end_sim();
    end
endmodule
`default_nettype wire
